// >>> rtl/rdtov_top.sv
// Residual definite-time overvoltage function with register port
//
// Strobed register access and the register addresses were left to the implementer.
module rdtov_top #(
    parameter int CYCLES_PER_MS = rdtov_pkg::CYC_PER_MS
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] residual_fundamental_rms_in,
    input  wire logic        block_input_in,
    output logic [15:0]      reg_rdata_out,
    output logic             general_start_out,
    output logic             general_trip_out,
    output logic             irq_out
);

    rdtov_tmr_if tmr_link ();

    logic        oper_reg;
    logic        start_only_reg;
    logic [5:0]  level_reg;
    logic [15:0] delay_reg;
    logic [15:0] rated_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_stat_next;
    logic [2:0]  irq_en_reg;
    logic [2:0]  irq_event;
    logic        int_start_reg;
    logic        int_start_next;
    logic        int_trip;
    logic        gen_start_next;
    logic        gen_trip_next;
    logic        above;
    logic        enabled;
    logic        wr_ctrl;
    logic        wr_level;
    logic        wr_delay;
    logic        wr_rated;
    logic        wr_irq_en;
    logic        wr_irq_clr;
    logic [15:0] eff_delay;
    logic [15:0] rdata_next;

    // Percentage of rated voltage, no divider needed
    function automatic logic above_level(
        input logic [15:0] rms,
        input logic [15:0] rated,
        input logic [5:0]  pct
    );
        logic [22:0] lhs;
        logic [22:0] rhs;
        lhs = 23'(rms) * 23'(rdtov_pkg::PERCENT_DIV);
        rhs = 23'(rated) * 23'(pct);
        return lhs > rhs;
    endfunction

    // Write decode shared by all setting registers
    function automatic logic wr_hit(
        input logic       wr,
        input logic [2:0] addr,
        input logic [2:0] target
    );
        return wr && (addr == target);
    endfunction

    assign wr_ctrl    = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_CTRL);
    assign wr_level   = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_LEVEL);
    assign wr_delay   = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_DELAY);
    assign wr_rated   = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_RATED);
    assign wr_irq_en  = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_IRQ_EN);
    assign wr_irq_clr = wr_hit(reg_wr_in, reg_addr_in,
                               rdtov_pkg::ADDR_IRQ_CLR);

    // Operation and start-only selects
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            oper_reg       <= rdtov_pkg::OPER_RST;
            start_only_reg <= rdtov_pkg::SONLY_RST;
        end else if (wr_ctrl) begin
            oper_reg       <= reg_wdata_in[rdtov_pkg::CTRL_OPER_BIT];
            start_only_reg <= reg_wdata_in[rdtov_pkg::CTRL_SONLY_BIT];
        end
    end

    // Out-of-range writes clamp, so the level never leaves its range
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            level_reg <= rdtov_pkg::LEVEL_RST;
        end else if (wr_level) begin
            if (reg_wdata_in < 16'(rdtov_pkg::LEVEL_MIN)) begin
                level_reg <= rdtov_pkg::LEVEL_MIN;
            end else if (reg_wdata_in > 16'(rdtov_pkg::LEVEL_MAX)) begin
                level_reg <= rdtov_pkg::LEVEL_MAX;
            end else begin
                level_reg <= reg_wdata_in[rdtov_pkg::LEVEL_W-1:0];
            end
        end
    end

    // Delay in ms, clamped at the top of its range
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            delay_reg <= rdtov_pkg::DELAY_RST;
        end else if (wr_delay) begin
            if (reg_wdata_in > rdtov_pkg::DELAY_MAX) begin
                delay_reg <= rdtov_pkg::DELAY_MAX;
            end else begin
                delay_reg <= reg_wdata_in;
            end
        end
    end

    // Rated voltage in the same units as the incoming magnitude
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rated_reg <= rdtov_pkg::RATED_RST;
        end else if (wr_rated) begin
            rated_reg <= reg_wdata_in;
        end
    end

    // Magnitude comes from upstream logic on this clock
    assign above   = above_level(residual_fundamental_rms_in,
                                 rated_reg, level_reg);
    assign enabled = oper_reg && !block_input_in;

    // Start follows the comparison; off or block holds it low
    assign int_start_next = above && enabled;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            int_start_reg <= 1'b0;
        end else begin
            int_start_reg <= int_start_next;
        end
    end

    // Short settings still respect the minimum operate time
    assign eff_delay = (delay_reg < rdtov_pkg::MIN_OPERATE_MS)
                     ? rdtov_pkg::MIN_OPERATE_MS : delay_reg;

    assign tmr_link.run      = int_start_reg;
    assign tmr_link.delay_ms = eff_delay;

    rdtov_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_timer (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .tmr      (tmr_link.tmr)
    );

    // Trip only once the timer expired with start still held
    assign int_trip = int_start_reg && tmr_link.expired;

    // Final gating
    assign gen_start_next = int_start_reg && enabled;
    assign gen_trip_next  = int_trip && enabled && !start_only_reg;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            general_start_out <= 1'b0;
            general_trip_out  <= 1'b0;
        end else begin
            general_start_out <= gen_start_next;
            general_trip_out  <= gen_trip_next;
        end
    end

    // Events taken from the gated outputs as software sees them
    assign irq_event[rdtov_pkg::IRQ_START_BIT] =
        gen_start_next && !general_start_out;
    assign irq_event[rdtov_pkg::IRQ_TRIP_BIT] =
        gen_trip_next && !general_trip_out;
    // Drop counts only when start fell without a trip
    assign irq_event[rdtov_pkg::IRQ_DROP_BIT] =
        !gen_start_next && general_start_out && !general_trip_out;

    // A new event beats a clear written in the same cycle
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_irq_clr) begin
            irq_stat_next = irq_stat_next
                          & ~reg_wdata_in[rdtov_pkg::IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_event;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_stat_reg <= 3'h0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_en_reg <= 3'h0;
        end else if (wr_irq_en) begin
            irq_en_reg <= reg_wdata_in[rdtov_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_next & irq_en_reg);
        end
    end

    // Read mux; unmapped and write-only words read zero
    always_comb begin
        rdata_next = 16'h0;
        case (reg_addr_in)
            rdtov_pkg::ADDR_CTRL: begin
                rdata_next[rdtov_pkg::CTRL_OPER_BIT]  = oper_reg;
                rdata_next[rdtov_pkg::CTRL_SONLY_BIT] = start_only_reg;
            end
            rdtov_pkg::ADDR_LEVEL: begin
                rdata_next[rdtov_pkg::LEVEL_W-1:0] = level_reg;
            end
            rdtov_pkg::ADDR_DELAY: begin
                rdata_next = delay_reg;
            end
            rdtov_pkg::ADDR_RATED: begin
                rdata_next = rated_reg;
            end
            rdtov_pkg::ADDR_STATUS: begin
                rdata_next[rdtov_pkg::STAT_START_BIT]  = general_start_out;
                rdata_next[rdtov_pkg::STAT_TRIP_BIT]   = general_trip_out;
                rdata_next[rdtov_pkg::STAT_INT_ST_BIT] = int_start_reg;
                rdata_next[rdtov_pkg::STAT_BLOCK_BIT]  = block_input_in;
            end
            rdtov_pkg::ADDR_IRQ_STAT: begin
                rdata_next[rdtov_pkg::IRQ_W-1:0] = irq_stat_reg;
            end
            rdtov_pkg::ADDR_IRQ_EN: begin
                rdata_next[rdtov_pkg::IRQ_W-1:0] = irq_en_reg;
            end
            default: begin
                rdata_next = 16'h0;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !reg_rd_in) begin
            reg_rdata_out <= 16'h0;
        end else begin
            reg_rdata_out <= rdata_next;
        end
    end

    // Checking helpers: cycles with start held
    logic [31:0] run_cnt_reg;
    logic [31:0] min_cyc;
    logic [31:0] set_cyc;

    assign min_cyc = 32'(rdtov_pkg::MIN_OPERATE_MS) * 32'(CYCLES_PER_MS);
    assign set_cyc = 32'(eff_delay) * 32'(CYCLES_PER_MS);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !int_start_reg) begin
            run_cnt_reg <= 32'h0;
        end else begin
            run_cnt_reg <= run_cnt_reg + 32'h1;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking

    default disable iff (!rst_n_in);

    // Block in the middle cycle may cancel the pending start
    chk_start_follows: assert property (
        int_start_next ##1 enabled |=> general_start_out
    ) else $error("start output missed a started state");

    chk_level_range: assert property (
        level_reg >= rdtov_pkg::LEVEL_MIN
        && level_reg <= rdtov_pkg::LEVEL_MAX
    ) else $error("start level outside its range");

    chk_delay_range: assert property (
        delay_reg <= rdtov_pkg::DELAY_MAX
    ) else $error("delay setting above its range");

    chk_trip_delay: assert property (
        int_trip |-> run_cnt_reg >= set_cyc
    ) else $error("trip before the set delay elapsed");

    chk_trip_min_time: assert property (
        int_trip |-> run_cnt_reg >= min_cyc
    ) else $error("trip before the minimum operate time");

    chk_off_quiet: assert property (
        !oper_reg |=> !general_start_out && !general_trip_out
    ) else $error("output active while operation is off");

    chk_start_only: assert property (
        start_only_reg |=> !general_trip_out
    ) else $error("trip output while start-only is set");

    chk_block_quiet: assert property (
        block_input_in |=> !general_start_out && !general_trip_out
    ) else $error("output active while blocked");

    chk_trip_has_start: assert property (
        general_trip_out |-> general_start_out
    ) else $error("trip output without start output");

    chk_restart_zero: assert property (
        $fell(int_start_reg) |=> !tmr_link.expired && run_cnt_reg == 32'h0
    ) else $error("timer kept state after start dropped");

    chk_irq_level: assert property (
        irq_out == |($past(irq_stat_next) & $past(irq_en_reg))
    ) else $error("interrupt output disagrees with status");

    cov_start: cover property ($rose(general_start_out));
    cov_trip: cover property ($rose(general_trip_out));
    cov_drop: cover property (
        general_start_out && !general_trip_out ##1 !general_start_out
    );
    cov_block: cover property (
        general_start_out ##1 block_input_in
    );
    cov_start_only: cover property (
        start_only_reg && general_start_out ##8 general_start_out
    );

endmodule

// >>> rtl/rdtov_pkg.sv
// Constants for the residual definite-time overvoltage function
package rdtov_pkg;

    localparam int ADDR_W   = 3;
    localparam int DATA_W   = 16;
    localparam int LEVEL_W  = 6;
    localparam int DELAY_W  = 16;
    localparam int IRQ_W    = 3;

    // Register word indexes
    localparam logic [2:0] ADDR_CTRL     = 3'h0;
    localparam logic [2:0] ADDR_LEVEL    = 3'h1;
    localparam logic [2:0] ADDR_DELAY    = 3'h2;
    localparam logic [2:0] ADDR_RATED    = 3'h3;
    localparam logic [2:0] ADDR_STATUS   = 3'h4;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
    localparam logic [2:0] ADDR_IRQ_EN   = 3'h6;
    localparam logic [2:0] ADDR_IRQ_CLR  = 3'h7;

    // Field positions
    localparam int CTRL_OPER_BIT   = 0;
    localparam int CTRL_SONLY_BIT  = 1;
    localparam int STAT_START_BIT  = 0;
    localparam int STAT_TRIP_BIT   = 1;
    localparam int STAT_INT_ST_BIT = 2;
    localparam int STAT_BLOCK_BIT  = 3;
    localparam int IRQ_START_BIT   = 0;
    localparam int IRQ_TRIP_BIT    = 1;
    localparam int IRQ_DROP_BIT    = 2;

    // Setting limits and reset values
    localparam logic [5:0]  LEVEL_MIN   = 6'h02;
    localparam logic [5:0]  LEVEL_MAX   = 6'h3C;
    localparam logic [5:0]  LEVEL_RST   = 6'h1E;
    localparam logic [15:0] DELAY_MAX   = 16'hEA60;
    localparam logic [15:0] DELAY_RST   = 16'h0064;
    localparam logic [15:0] RATED_RST   = 16'h2710;
    localparam logic        OPER_RST    = 1'b1;
    localparam logic        SONLY_RST   = 1'b0;
    localparam logic [6:0]  PERCENT_DIV = 7'h64;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_IN_NS      = 1000000;
    localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MIN_OPERATE_MS = 16'h0032;

endpackage

// >>> rtl/rdtov_tmr_if.sv
// Link between the decision logic and the delay timer
interface rdtov_tmr_if;
    logic        run;
    logic [15:0] delay_ms;
    logic        expired;
    modport ctl (output run, output delay_ms, input expired);
    modport tmr (input run, input delay_ms, output expired);
endinterface

// >>> rtl/rdtov_timer.sv
// Millisecond delay timer, restarted whenever run drops
module rdtov_timer #(
    parameter int CYCLES_PER_MS = rdtov_pkg::CYC_PER_MS
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    rdtov_tmr_if.tmr  tmr
);

    logic [31:0] pres_reg;
    logic [15:0] ms_reg;
    logic        expired_reg;
    logic        tick;

    assign tick = (pres_reg == 32'(CYCLES_PER_MS - 1));

    // Prescaler: one tick per millisecond of run time
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !tmr.run) begin
            pres_reg <= 32'h0;
        end else if (tick) begin
            pres_reg <= 32'h0;
        end else begin
            pres_reg <= pres_reg + 32'h1;
        end
    end

    // Elapsed ms; clearing on idle gives a fresh count
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !tmr.run) begin
            ms_reg <= 16'h0;
        end else if (tick && ms_reg < tmr.delay_ms) begin
            ms_reg <= ms_reg + 16'h1;
        end
    end

    // Only the set delay decides expiry, not the overshoot
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            expired_reg <= 1'b0;
        end else begin
            expired_reg <= tmr.run && (ms_reg >= tmr.delay_ms);
        end
    end

    assign tmr.expired = expired_reg;

endmodule

// >>> tb/rdtov_src_model.sv
// Upstream magnitude stage and user block logic feeding the function
module rdtov_src_model (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] rms_req_in,
    input  wire logic        blk_req_in,
    output logic [15:0]      rms_out,
    output logic             blk_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Registered like a real preprocessing stage: one cycle of latency
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rms_out <= 16'h0000;
            blk_out <= 1'b0;
        end else begin
            rms_out <= rms_req_in;
            blk_out <= blk_req_in;
        end
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the residual overvoltage function
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CPM = 2;
    typedef struct {
        logic [2:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } rdtov_row_t;

    logic        clock_in     = 1'b0;
    logic        rst_n_in     = 1'b0;
    logic [2:0]  reg_addr_in  = 3'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [15:0] rms_req      = 16'h0000;
    logic        blk_req      = 1'b0;
    logic [15:0] rms_w;
    logic        blk_w;
    logic [15:0] reg_rdata_out;
    logic        general_start_out;
    logic        general_trip_out;
    logic        irq_out;
    int          fails   = 0;
    int          checked = 0;
    int          n0;
    int          n1;
    rdtov_row_t  rows [11];

    always #20 clock_in = ~clock_in;

    rdtov_top #(.CYCLES_PER_MS(CPM)) DUT (
        .clock_in                    (clock_in),
        .rst_n_in                    (rst_n_in),
        .reg_addr_in                 (reg_addr_in),
        .reg_wdata_in                (reg_wdata_in),
        .reg_wr_in                   (reg_wr_in),
        .reg_rd_in                   (reg_rd_in),
        .residual_fundamental_rms_in (rms_w),
        .block_input_in              (blk_w),
        .reg_rdata_out               (reg_rdata_out),
        .general_start_out           (general_start_out),
        .general_trip_out            (general_trip_out),
        .irq_out                     (irq_out)
    );

    rdtov_src_model src (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .rms_req_in (rms_req),
        .blk_req_in (blk_req),
        .rms_out    (rms_w),
        .blk_out    (blk_w)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clock_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        `CHK("reg_rdata_out", e, reg_rdata_out)
    endtask

    task automatic set_rms(input logic [15:0] v);
        @(posedge clock_in);
        rms_req <= v;
    endtask

    // Cycles from raising the magnitude until trip, then fall back
    task automatic trip_time(input logic [15:0] v, output int n);
        set_rms(v);
        n = 0;
        while (general_trip_out !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 400) begin
                fails++;
                end_of_test();
            end
        end
        set_rms(16'h0000);
        cyc(5);
    endtask

    initial begin
        rows[0] = '{rdtov_pkg::ADDR_LEVEL, 16'h0000, 16'h0002};
        rows[1] = '{rdtov_pkg::ADDR_LEVEL, 16'h003F, 16'h003C};
        rows[2] = '{rdtov_pkg::ADDR_LEVEL, 16'h001E, 16'h001E};
        rows[3] = '{rdtov_pkg::ADDR_DELAY, 16'hEA61, 16'hEA60};
        rows[4] = '{rdtov_pkg::ADDR_DELAY, 16'h0000, 16'h0000};
        rows[5] = '{rdtov_pkg::ADDR_STATUS, 16'h000F, 16'h0000};
        rows[6] = '{rdtov_pkg::ADDR_IRQ_CLR, 16'h0007, 16'h0000};
        rows[7] = '{rdtov_pkg::ADDR_IRQ_EN, 16'h0007, 16'h0007};
        rows[8] = '{rdtov_pkg::ADDR_IRQ_EN, 16'h0000, 16'h0000};
        rows[9] = '{rdtov_pkg::ADDR_RATED, 16'h1388, 16'h1388};
        rows[10] = '{rdtov_pkg::ADDR_RATED, 16'h2710, 16'h2710};
        cyc(5);
        `CHK("start_in_reset", 1'b0, general_start_out)
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(rdtov_pkg::ADDR_CTRL, 16'h0001);
        rd(rdtov_pkg::ADDR_LEVEL, 16'h001E);
        rd(rdtov_pkg::ADDR_DELAY, 16'h0064);
        rd(rdtov_pkg::ADDR_RATED, 16'h2710);
        rd(rdtov_pkg::ADDR_IRQ_STAT, 16'h0000);
        cyc(1);
        `CHK("rdata_idle", 16'h0000, reg_rdata_out)
        for (int i = 0; i < 11; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // Threshold 3000 with rated 10000 and 30 percent, strict
        set_rms(16'h0BB8);
        cyc(6);
        `CHK("start_at_level", 1'b0, general_start_out)
        set_rms(16'h0BB9);
        cyc(3);
        `CHK("start_above", 1'b1, general_start_out)
        rd(rdtov_pkg::ADDR_STATUS, 16'h0005);
        set_rms(16'h0000);
        cyc(4);
        `CHK("start_drop", 1'b0, general_start_out)
        // Zero delay still runs the minimum operate time
        trip_time(16'h0BB9, n0);
        `CHK("trip_min", 1'b1, n0 >= 101 && n0 <= 107)
        trip_time(16'hEA60, n1);
        `CHK("trip_overshoot", n0, n1)
        wr(rdtov_pkg::ADDR_DELAY, 16'h003C);
        trip_time(16'h0BB9, n0);
        `CHK("trip_60ms", 1'b1, n0 >= 121 && n0 <= 127)
        // Interrupted start must restart the count from zero
        set_rms(16'h0BB9);
        cyc(90);
        set_rms(16'h0000);
        cyc(4);
        trip_time(16'h0BB9, n1);
        `CHK("trip_restart", n0, n1)
        wr(rdtov_pkg::ADDR_CTRL, 16'h0003);
        set_rms(16'h0BB9);
        cyc(160);
        `CHK("sonly_start", 1'b1, general_start_out)
        `CHK("sonly_trip", 1'b0, general_trip_out)
        wr(rdtov_pkg::ADDR_CTRL, 16'h0000);
        cyc(10);
        `CHK("off_start", 1'b0, general_start_out)
        `CHK("off_trip", 1'b0, general_trip_out)
        wr(rdtov_pkg::ADDR_CTRL, 16'h0001);
        set_rms(16'h0000);
        cyc(4);
        trip_time(16'h0BB9, n1);
        `CHK("trip_after_off", n0, n1)
        set_rms(16'h0BB9);
        cyc(140);
        `CHK("pre_block_trip", 1'b1, general_trip_out)
        rd(rdtov_pkg::ADDR_STATUS, 16'h0007);
        @(posedge clock_in);
        blk_req <= 1'b1;
        cyc(3);
        `CHK("blk_start", 1'b0, general_start_out)
        `CHK("blk_trip", 1'b0, general_trip_out)
        rd(rdtov_pkg::ADDR_STATUS, 16'h0008);
        @(posedge clock_in);
        blk_req <= 1'b0;
        set_rms(16'h0000);
        cyc(4);
        // Interrupt raised, cleared, then masked
        rd(rdtov_pkg::ADDR_IRQ_STAT, 16'h0007);
        wr(rdtov_pkg::ADDR_IRQ_CLR, 16'h0007);
        wr(rdtov_pkg::ADDR_IRQ_EN, 16'h0001);
        set_rms(16'h0BB9);
        cyc(5);
        `CHK("irq_start", 1'b1, irq_out)
        rd(rdtov_pkg::ADDR_IRQ_STAT, 16'h0001);
        wr(rdtov_pkg::ADDR_IRQ_CLR, 16'h0001);
        cyc(2);
        `CHK("irq_cleared", 1'b0, irq_out)
        wr(rdtov_pkg::ADDR_IRQ_EN, 16'h0000);
        set_rms(16'h0000);
        cyc(5);
        rd(rdtov_pkg::ADDR_IRQ_STAT, 16'h0004);
        `CHK("irq_masked", 1'b0, irq_out)
        // Second reset in mid-run brings settings back
        wr(rdtov_pkg::ADDR_LEVEL, 16'h0014);
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        cyc(2);
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(rdtov_pkg::ADDR_LEVEL, 16'h001E);
        rd(rdtov_pkg::ADDR_CTRL, 16'h0001);
        end_of_test();
    end
endmodule
